// file: dmlc_pkg.sv
// package: field positions, encodings and types for the mode-latency block
package dmlc_pkg;

  // pin bundle sampled on each dram clock rising edge
  typedef struct packed {
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [17:0] addr;
  } dmlc_cmd_t;

  localparam int CMD_W = $bits(dmlc_cmd_t);

  // mode register select codes
  localparam logic [2:0] MRS_SEL_MR1    = 3'h1;
  localparam logic [2:0] MRS_SEL_MR2    = 3'h2;
  localparam logic [2:0] MRS_SEL_DNU    = 3'h7;

  // mode register widths and reset values
  localparam int          MR_W          = 22;
  localparam logic [21:0] MR1_RESET     = 22'h000000;
  localparam logic [21:0] MR2_RESET     = 22'h000000;

  // mode register one field positions
  localparam int MR1_AL_LO      = 3;
  localparam int MR1_EQ_LO      = 5;
  localparam int MR1_EQ_HI      = 13;
  localparam int MR1_EXTRA_STROBE_TERMINATION_BIT   = 11;
  localparam int MR1_QOFF_BIT   = 12;

  // mode register two field positions
  localparam int MR2_CWL_LO     = 3;
  localparam int MR2_LOW_POWER_REFRESH_RANGE_LO   = 6;
  localparam int MR2_RTTWR_LO   = 9;
  localparam int MR2_CRC_BIT    = 12;
  localparam int MR2_RSV13_BIT  = 13;
  localparam int MR2_RSV17_BIT  = 17;
  localparam int MR2_RSV21_BIT  = 21;

  // command-hold encodings
  localparam logic [1:0] AL_OFF       = 2'h0;
  localparam logic [1:0] AL_CL_MINUS1 = 2'h1;
  localparam logic [1:0] AL_CL_MINUS2 = 2'h2;

  // write-time termination encodings
  typedef enum logic [2:0] {
    WTT_OFF   = 3'h0,
    WTT_240   = 3'h2,
    WTT_HIZ   = 3'h3,
    WTT_80    = 3'h4
  } dmlc_wtt_t;

  // self-refresh temperature range
  typedef enum logic [1:0] {
    SRT_NORMAL   = 2'h0,
    SRT_REDUCED  = 2'h1,
    SRT_EXTENDED = 2'h2,
    SRT_AUTO     = 2'h3
  } dmlc_srt_t;

  // write column delay in clocks, one-clock write preamble
  function automatic logic [4:0] dmlc_cwl(input logic [2:0] code);
    logic [4:0] v;
    v = 5'h09;
    case (code)
      3'h0:    v = 5'h09;
      3'h1:    v = 5'h0a;
      3'h2:    v = 5'h0b;
      3'h3:    v = 5'h0c;
      3'h4:    v = 5'h0e;
      3'h5:    v = 5'h10;
      3'h6:    v = 5'h12;
      default: v = 5'h14;
    endcase
    return v;
  endfunction : dmlc_cwl

endpackage : dmlc_pkg

// file: dmlc_hold_line.sv
// delay line that holds a command pulse for a selectable number of dram clocks
`timescale 1ns/100ps
module dmlc_hold_line
  import dmlc_pkg::*;
#(
  parameter int MAX_HOLD = 32
) (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_b_i,
  // dram clock edge enable
  input  wire logic                        ck_edge_i,
  // command in, hold count, delayed command out
  input  wire logic                        cmd_i,
  input  wire logic [$clog2(MAX_HOLD+1)-1:0] hold_i,
  output logic                             exec_o
);

  logic [MAX_HOLD:1] pipe_q;
  logic              tap;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pipe_q <= '0;
    end else if (ck_edge_i) begin
      pipe_q <= {pipe_q[MAX_HOLD-1:1], cmd_i};
    end
  end

  // a hold of zero passes the command straight through on its own edge
  always_comb begin
    tap = cmd_i;
    if (hold_i != '0 && hold_i <= MAX_HOLD[$clog2(MAX_HOLD+1)-1:0]) begin
      tap = pipe_q[hold_i];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      exec_o <= 1'b0;
    end else begin
      exec_o <= ck_edge_i & tap;
    end
  end

endmodule : dmlc_hold_line

// file: dmlc_top.sv
// mode-register configuration and latency logic of the dram
`timescale 1ns/100ps
module dmlc_top
  import dmlc_pkg::*;
#(
  parameter int DEV_WIDTH = 8,
  parameter int MAX_HOLD  = 32
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // dram clock and command pins, asynchronous to clock_i
  input  wire logic        ck_i,
  input  wire dmlc_cmd_t   cmd_i,
  // settings held elsewhere in the device
  input  wire logic [5:0]  read_column_delay_i,
  input  wire logic [3:0]  parity_delay_i,
  input  wire logic        write_byte_mask_req_i,
  input  wire logic        write_bus_inversion_req_i,
  input  wire logic        read_bus_inversion_req_i,
  // delayed internal command pulses
  output logic             int_read_o,
  output logic             int_write_o,
  // latencies in dram clocks
  output logic [5:0]       command_hold_delay_o,
  output logic [4:0]       write_column_delay_o,
  output logic [6:0]       total_read_latency_o,
  output logic [7:0]       total_write_latency_o,
  // decoded settings
  output logic [2:0]       rx_equalizer_o,
  output logic             output_enable_o,
  output logic             extra_strobe_termination_o,
  output logic             strobe_termination_o,
  output logic             write_byte_mask_o,
  output logic             write_bus_inversion_o,
  output logic             read_bus_inversion_o,
  output logic             crc_check_o,
  output dmlc_wtt_t        write_time_termination_o,
  output dmlc_srt_t        low_power_refresh_range_o,
  output logic             auto_temp_refresh_o,
  output logic             config_error_o
);

  localparam int HW = $clog2(MAX_HOLD + 1);

  // synchronisers: stage one is read only by stage two
  logic            ck_s1_q, ck_s2_q, ck_s3_q;
  dmlc_cmd_t       cmd_s1_q, cmd_s2_q;
  logic            ck_edge;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ck_s1_q <= 1'b0;
      ck_s2_q <= 1'b0;
      ck_s3_q <= 1'b0;
    end else begin
      ck_s1_q <= ck_i;
      ck_s2_q <= ck_s1_q;
      ck_s3_q <= ck_s2_q;
    end
  end

  // idle pins are high so a reset does not look like a command
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_s1_q <= '1;
      cmd_s2_q <= '1;
    end else begin
      cmd_s1_q <= cmd_i;
      cmd_s2_q <= cmd_s1_q;
    end
  end

  // pins are sampled on the synchronised rising edge of the dram clock
  assign ck_edge = ck_s2_q & ~ck_s3_q;

  // command decode
  logic       cmd_sel;
  logic       is_mrs;
  logic       is_read;
  logic       is_write;
  logic [2:0] mr_sel;
  logic [21:0] mr_val;

  assign cmd_sel  = ck_edge & ~cmd_s2_q.cs_n & cmd_s2_q.act_n;
  assign is_mrs   = cmd_sel & ~cmd_s2_q.ras_n & ~cmd_s2_q.cas_n & ~cmd_s2_q.we_n;
  assign is_read  = cmd_sel & cmd_s2_q.ras_n & ~cmd_s2_q.cas_n & cmd_s2_q.we_n;
  assign is_write = cmd_sel & cmd_s2_q.ras_n & ~cmd_s2_q.cas_n & ~cmd_s2_q.we_n;
  // pin to bit mapping; a14..a16 carry no mode bits
  assign mr_val   = {cmd_s2_q.bg, cmd_s2_q.ba, cmd_s2_q.addr[17], 3'h0,
                     cmd_s2_q.addr[13:0]};
  assign mr_sel   = mr_val[20:18];

  // mode registers one and two
  logic [21:0] mr1_q;
  logic [21:0] mr2_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mr1_q <= MR1_RESET;
    end else if (is_mrs && mr_sel == MRS_SEL_MR1) begin
      mr1_q <= mr_val;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mr2_q <= MR2_RESET;
    end else if (is_mrs && mr_sel == MRS_SEL_MR2) begin
      mr2_q <= mr_val;
    end
  end

  // reserved encoding check on each mode set
  logic       bad_write;
  logic [2:0] new_wtt;

  always_comb begin
    new_wtt   = mr_val[MR2_RTTWR_LO +: 3];
    bad_write = 1'b0;
    if (mr_sel == MRS_SEL_DNU) begin
      bad_write = 1'b1;
    end else if (mr_sel == MRS_SEL_MR1) begin
      bad_write = (mr_val[MR1_AL_LO +: 2] == 2'h3)
                | (mr_val[MR1_EXTRA_STROBE_TERMINATION_BIT] && DEV_WIDTH != 8);
    end else if (mr_sel == MRS_SEL_MR2) begin
      bad_write = mr_val[MR2_RSV21_BIT] | mr_val[MR2_RSV17_BIT]
                | mr_val[MR2_RSV13_BIT] | (new_wtt == 3'h1) | (new_wtt > 3'h4);
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      config_error_o <= 1'b0;
    end else if (is_mrs) begin
      config_error_o <= bad_write;
    end
  end

  // latency arithmetic, all whole clocks
  logic [5:0] hold_d;

  always_comb begin
    case (mr1_q[MR1_AL_LO +: 2])
      AL_CL_MINUS1: hold_d = read_column_delay_i - 6'h01;
      AL_CL_MINUS2: hold_d = read_column_delay_i - 6'h02;
      default:      hold_d = 6'h00; // reserved code treated as off
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      command_hold_delay_o  <= 6'h00;
      write_column_delay_o  <= 5'h09;
      total_read_latency_o  <= 7'h00;
      total_write_latency_o <= 8'h00;
    end else begin
      command_hold_delay_o  <= hold_d;
      write_column_delay_o  <= dmlc_cwl(mr2_q[MR2_CWL_LO +: 3]);
      total_read_latency_o  <= {1'b0, hold_d} + {1'b0, read_column_delay_i};
      total_write_latency_o <= {2'h0, hold_d} + {4'h0, parity_delay_i}
                             + {3'h0, dmlc_cwl(mr2_q[MR2_CWL_LO +: 3])};
    end
  end

  // command hold: read/write executes hold_d dram clocks after it was taken, capped at MAX_HOLD
  logic [HW-1:0] hold_cnt;

  assign hold_cnt = (hold_d > MAX_HOLD[5:0]) ? MAX_HOLD[HW-1:0] : hold_d[HW-1:0];

  dmlc_hold_line #(
    .MAX_HOLD (MAX_HOLD)
  ) u_read_hold (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .ck_edge_i (ck_edge),
    .cmd_i     (is_read),
    .hold_i    (hold_cnt),
    .exec_o    (int_read_o)
  );

  dmlc_hold_line #(
    .MAX_HOLD (MAX_HOLD)
  ) u_write_hold (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .ck_edge_i (ck_edge),
    .cmd_i     (is_write),
    .hold_i    (hold_cnt),
    .exec_o    (int_write_o)
  );

  // pin sharing and termination decode
  logic extra_strobe_termination_on;

  assign extra_strobe_termination_on = mr1_q[MR1_EXTRA_STROBE_TERMINATION_BIT];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_equalizer_o             <= 3'h0;
      output_enable_o            <= 1'b1;
      extra_strobe_termination_o <= 1'b0;
      strobe_termination_o       <= 1'b0;
      write_byte_mask_o          <= 1'b0;
      write_bus_inversion_o      <= 1'b0;
      read_bus_inversion_o       <= 1'b0;
    end else begin
      // code is opaque; 000 is the vendor default
      rx_equalizer_o             <= {mr1_q[MR1_EQ_HI], mr1_q[MR1_EQ_LO +: 2]};
      output_enable_o            <= ~mr1_q[MR1_QOFF_BIT];
      extra_strobe_termination_o <= extra_strobe_termination_on;
      strobe_termination_o       <= extra_strobe_termination_on;
      // mask wins a clash so the shared pin never carries both meanings
      write_byte_mask_o          <= ~extra_strobe_termination_on & write_byte_mask_req_i;
      write_bus_inversion_o      <= ~extra_strobe_termination_on & write_bus_inversion_req_i
                                  & ~write_byte_mask_req_i;
      read_bus_inversion_o       <= ~extra_strobe_termination_on & read_bus_inversion_req_i;
    end
  end

  // mode register two decode
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      crc_check_o               <= 1'b0;
      write_time_termination_o  <= WTT_OFF;
      low_power_refresh_range_o <= SRT_NORMAL;
      auto_temp_refresh_o       <= 1'b0;
    end else begin
      crc_check_o               <= mr2_q[MR2_CRC_BIT];
      case (mr2_q[MR2_RTTWR_LO +: 3])
        WTT_240: write_time_termination_o <= WTT_240;
        WTT_HIZ: write_time_termination_o <= WTT_HIZ;
        WTT_80:  write_time_termination_o <= WTT_80;
        default: write_time_termination_o <= WTT_OFF; // reserved reads as off
      endcase
      low_power_refresh_range_o <= dmlc_srt_t'(mr2_q[MR2_LOW_POWER_REFRESH_RANGE_LO +: 2]);
      auto_temp_refresh_o       <= (mr2_q[MR2_LOW_POWER_REFRESH_RANGE_LO +: 2] == SRT_AUTO);
    end
  end

endmodule : dmlc_top

// file: dmlc_props.sv
// checker: latency sums, code ranges and pin-sharing relations
`timescale 1ns/100ps
module dmlc_props
  import dmlc_pkg::*;
(
  // clock and reset
  input wire logic       clock_i,
  input wire logic       rst_b_i,
  // watched ports
  input wire logic [5:0] read_column_delay_i,
  input wire logic [3:0] parity_delay_i,
  input wire logic       int_read_o,
  input wire logic       int_write_o,
  input wire logic [5:0] command_hold_delay_o,
  input wire logic [4:0] write_column_delay_o,
  input wire logic [6:0] total_read_latency_o,
  input wire logic [7:0] total_write_latency_o,
  input wire logic       extra_strobe_termination_o,
  input wire logic       strobe_termination_o,
  input wire logic       write_byte_mask_o,
  input wire logic       write_bus_inversion_o,
  input wire logic       read_bus_inversion_o,
  input wire dmlc_srt_t  low_power_refresh_range_o,
  input wire logic       auto_temp_refresh_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // sums judged only once their terms held three cycles: outputs lag a clock
  logic [20:0] s1_q;
  logic [20:0] s2_q;
  logic [2:0]  up_q;
  wire  [20:0] snap = {command_hold_delay_o, read_column_delay_i,
                       parity_delay_i, write_column_delay_o};
  wire         steady = up_q[2] && snap == s1_q && s1_q == s2_q;
  always_ff @(posedge clock_i) begin
    s1_q <= snap;
    s2_q <= s1_q;
  end
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) up_q <= 3'h0;
    else up_q <= {up_q[1:0], 1'b1};
  end
  a_read_sum: assert property (steady |-> total_read_latency_o ==
    7'(command_hold_delay_o) + 7'(read_column_delay_i)) else $error("read latency sum");
  a_write_sum: assert property (steady |-> total_write_latency_o == 8'(command_hold_delay_o)
    + 8'(parity_delay_i) + 8'(write_column_delay_o)) else $error("write latency sum");
  a_hold_value: assert property (steady |-> command_hold_delay_o == 6'h00 ||
    command_hold_delay_o == read_column_delay_i - 6'h01 ||
    command_hold_delay_o == read_column_delay_i - 6'h02) else $error("hold value");
  a_cwl_set: assert property (write_column_delay_o inside
    {5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14}) else $error("write column");
  a_extra_strobe_termination_share: assert property (extra_strobe_termination_o |-> !write_byte_mask_o &&
    !write_bus_inversion_o && !read_bus_inversion_o) else $error("shared pin");
  a_mask_excl: assert property (!(write_byte_mask_o && write_bus_inversion_o))
    else $error("mask and inversion");
  a_strobe_term: assert property (strobe_termination_o == extra_strobe_termination_o)
    else $error("strobe termination");
  a_auto_range: assert property (auto_temp_refresh_o ==
    (low_power_refresh_range_o == SRT_AUTO)) else $error("auto refresh");
  a_exec_pulse: assert property (int_read_o || int_write_o |=> !int_read_o && !int_write_o)
    else $error("exec pulse");
endmodule : dmlc_props
bind dmlc_top dmlc_props i_props (.clock_i, .rst_b_i, .read_column_delay_i, .parity_delay_i,
  .int_read_o, .int_write_o, .command_hold_delay_o, .write_column_delay_o,
  .total_read_latency_o, .total_write_latency_o, .extra_strobe_termination_o,
  .strobe_termination_o, .write_byte_mask_o, .write_bus_inversion_o,
  .read_bus_inversion_o, .low_power_refresh_range_o, .auto_temp_refresh_o);

// file: dmlc_ctl_model.sv
// controller model: drives dram clock and command pins, one command a frame
`timescale 1ns/100ps
module dmlc_ctl_model
  import dmlc_pkg::*;
(
  // system clock
  input  wire logic clock_i,
  // dram clock and command pins
  output logic      ck_o,
  output dmlc_cmd_t cmd_o
);
  initial begin
    ck_o = 1'b0;
    cmd_o = '1;
  end
  // mode set: ras, cas, we low; select on bg0/ba; reserved bits left 0
  function automatic dmlc_cmd_t mrs(input logic [2:0] s, input logic [13:0] v);
    return dmlc_cmd_t'({5'b01000, 1'b0, s, 4'h0, v});
  endfunction : mrs
  // 125 ns frame; ck stands still low between frames
  task automatic send(input dmlc_cmd_t c);
    @(posedge clock_i);
    cmd_o <= c;
    repeat (6) @(posedge clock_i);
    ck_o <= 1'b1;
    repeat (12) @(posedge clock_i);
    ck_o <= 1'b0;
    repeat (6) @(posedge clock_i);
    // released pins show inverse so stale values cannot pass
    cmd_o <= {1'b1, ~c[CMD_W-2:0]};
  endtask : send
endmodule : dmlc_ctl_model

// file: dram_mode_latency_config_bench.sv
// self-checking bench of the mode-latency block
`timescale 1ns/100ps
module dram_mode_latency_config_bench;
  import dmlc_pkg::*;
  logic clock_i = 1'b0, rst_b_i = 1'b0, ck_i;
  dmlc_cmd_t cmd_i;
  logic [5:0] read_column_delay_i = 6'h05, command_hold_delay_o;
  logic [3:0] parity_delay_i = 4'h3;
  logic write_byte_mask_req_i = 1'b0, write_bus_inversion_req_i = 1'b0;
  logic read_bus_inversion_req_i = 1'b0, int_read_o, int_write_o, output_enable_o;
  logic [4:0] write_column_delay_o;
  logic [6:0] total_read_latency_o;
  logic [7:0] total_write_latency_o;
  logic [2:0] rx_equalizer_o;
  logic extra_strobe_termination_o, strobe_termination_o, write_byte_mask_o;
  logic write_bus_inversion_o, read_bus_inversion_o, crc_check_o, auto_temp_refresh_o;
  logic config_error_o;
  dmlc_wtt_t write_time_termination_o;
  dmlc_srt_t low_power_refresh_range_o;
  int err_count = 0, n_tests = 0, rd_n = 0, wr_n = 0;
  logic [4:0] cw [8] = '{5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10, 5'h12, 5'h14};

  always #2.5 clock_i = ~clock_i;

  dmlc_ctl_model i_ctl (.clock_i, .ck_o(ck_i), .cmd_o(cmd_i));
  dmlc_top i_dut (.clock_i, .rst_b_i, .ck_i, .cmd_i, .read_column_delay_i, .parity_delay_i,
    .write_byte_mask_req_i, .write_bus_inversion_req_i, .read_bus_inversion_req_i,
    .int_read_o, .int_write_o, .command_hold_delay_o, .write_column_delay_o,
    .total_read_latency_o, .total_write_latency_o, .rx_equalizer_o, .output_enable_o,
    .extra_strobe_termination_o, .strobe_termination_o, .write_byte_mask_o,
    .write_bus_inversion_o, .read_bus_inversion_o, .crc_check_o, .write_time_termination_o,
    .low_power_refresh_range_o, .auto_temp_refresh_o, .config_error_o);

  always @(posedge clock_i) begin
    if (int_read_o === 1'b1) rd_n++;
    if (int_write_o === 1'b1) wr_n++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic mr(input logic [2:0] s, input logic [13:0] v);
    i_ctl.send(i_ctl.mrs(s, v));
  endtask : mr

  task automatic t_mr2;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      mr(3'h2, {1'b0, c[0], 4'h0, c[1:0], c, 3'h0});
      chk("cwl", write_column_delay_o, cw[i]);
      chk("wl", total_write_latency_o, cw[i] + 8'h03);
      chk("crc", crc_check_o, c[0]);
      chk("srt", low_power_refresh_range_o, c[1:0]);
      chk("asr", auto_temp_refresh_o, c[1:0] == 2'h3);
    end
    // parity delay must show up in write latency, code 111 leaves 20 clocks
    @(posedge clock_i);
    parity_delay_i <= 4'h7;
    repeat (3) @(posedge clock_i);
    chk("wl_par", total_write_latency_o, 8'h1b);
    parity_delay_i <= 4'h3;
  endtask : t_mr2

  task automatic t_wtt;
    logic [2:0] c;
    logic ok;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      ok = c inside {3'h0, 3'h2, 3'h3, 3'h4};
      mr(3'h2, {2'h0, c, 9'h000});
      chk("wtt", write_time_termination_o, ok ? c : 3'h0);
      chk("wtt_err", config_error_o, !ok);
    end
    mr(3'h7, 14'h0000);
    chk("sel_err", config_error_o, 1'b1);
    mr(3'h2, 14'h0000);
    chk("sel_ok", config_error_o, 1'b0);
  endtask : t_wtt

  task automatic t_mr1;
    logic [5:0] h [3] = '{6'h00, 6'h04, 6'h03};
    logic [2:0] e;
    for (int i = 0; i < 4; i++) begin
      mr(3'h1, 14'(i << 3));
      chk("al", command_hold_delay_o, i < 3 ? h[i] : 6'h00);
      chk("rl", total_read_latency_o, (i < 3 ? h[i] : 6'h00) + 7'h05);
      chk("wl1", total_write_latency_o, (i < 3 ? h[i] : 6'h00) + 8'h0c);
      chk("al_err", config_error_o, i == 3);
    end
    for (int i = 0; i < 8; i++) begin
      e = 3'(i);
      mr(3'h1, {e[2], 6'h00, e[1:0], 5'h00});
      chk("rx_equalizer", rx_equalizer_o, e);
    end
    mr(3'h1, 14'h1000);
    chk("qoff", output_enable_o, 1'b0);
    mr(3'h1, 14'h0000);
    chk("qon", output_enable_o, 1'b1);
  endtask : t_mr1

  task automatic t_pins(input logic m, input logic w, input logic r, input logic [3:0] ex);
    @(posedge clock_i);
    write_byte_mask_req_i <= m;
    write_bus_inversion_req_i <= w;
    read_bus_inversion_req_i <= r;
    repeat (4) @(posedge clock_i);
    chk("pins", {extra_strobe_termination_o, write_byte_mask_o, write_bus_inversion_o,
      read_bus_inversion_o}, ex);
    chk("sterm", strobe_termination_o, ex[3]);
  endtask : t_pins

  task automatic t_exec;
    int r0;
    i_ctl.send(dmlc_cmd_t'({5'b01101, 22'h0}));
    chk("rd0", rd_n, 1);
    i_ctl.send(dmlc_cmd_t'({5'b01100, 22'h0}));
    chk("wr0", wr_n, 1);
    @(posedge clock_i);
    read_column_delay_i <= 6'h03;
    mr(3'h1, 14'h0008);
    chk("al2", command_hold_delay_o, 6'h02);
    i_ctl.send(dmlc_cmd_t'({5'b01101, 22'h0}));
    r0 = rd_n;
    i_ctl.send(dmlc_cmd_t'('1));
    chk("rd_wait", rd_n, r0);
    i_ctl.send(dmlc_cmd_t'('1));
    chk("rd_late", rd_n, r0 + 1);
  endtask : t_exec

  task automatic end_of_test;
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clock_i);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk("rst_oe", output_enable_o, 1'b1);
    chk("rst_cwl", write_column_delay_o, 5'h09);
    chk("rst_rl", total_read_latency_o, 7'h05);
    t_mr2();
    t_wtt();
    t_mr1();
    t_pins(1'b1, 1'b1, 1'b1, 4'h5);
    t_pins(1'b0, 1'b1, 1'b0, 4'h2);
    // byte-wide part, so enabling extra strobe termination is legal
    mr(3'h1, 14'h0800);
    chk("extra_strobe_termination_err", config_error_o, 1'b0);
    t_pins(1'b1, 1'b0, 1'b1, 4'h8);
    mr(3'h1, 14'h0000);
    t_exec();
    end_of_test();
  end
endmodule : dram_mode_latency_config_bench
